/* bcsc_pkg.sv */
`default_nettype none
package bcsc_pkg;
  typedef enum logic [4:0] {
    OP_BRANCH_ACCUM_ZERO,
    OP_BRANCH_ACCUM_NONZERO,
    OP_BRANCH_ON_CARRY,
    OP_BRANCH_ON_NO_CARRY,
    OP_JUMP_BIT_SET,
    OP_JUMP_BIT_CLEAR,
    OP_JUMP_BIT_THEN_CLEAR,
    OP_SHORT_RELATIVE_JUMP,
    OP_LONG_JUMP,
    OP_BLOCK_ABSOLUTE_JUMP,
    OP_LONG_SUBROUTINE_CALL,
    OP_BLOCK_SUBROUTINE_CALL,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT,
    OP_COMPARE_JUMP_UNEQUAL,
    OP_DECREMENT_BRANCH_NONZERO,
    OP_PUSH,
    OP_POP
  } bcsc_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_S1, ST_S2, ST_S3} bcsc_state_t;

  localparam logic [15:0] LEN_ONE      = 16'h0001;
  localparam logic [15:0] LEN_TWO      = 16'h0002;
  localparam logic [15:0] LEN_THREE    = 16'h0003;
  localparam logic [15:0] IRQ_VEC_BASE = 16'h0003;
  localparam int          IRQ_VEC_SHIFT = 3;
  localparam logic [7:0]  SP_STEP_ONE  = 8'h01;
  localparam logic [7:0]  SP_STEP_TWO  = 8'h02;
  localparam logic [7:0]  SP_RESET     = 8'h07;
endpackage
`default_nettype wire

/* bcsc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module bcsc_core
  import bcsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        op_valid,
  input  wire bcsc_op_t    op_kind,
  input  wire logic [15:0] op_pc,
  input  wire logic [7:0]  op_byte2,
  input  wire logic [7:0]  op_byte3,
  input  wire logic [2:0]  op_page,
  input  wire logic        decrement_branch_nonzero_direct,
  input  wire logic [7:0]  accum,
  input  wire logic        carry_in,
  input  wire logic        bit_value,
  input  wire logic [7:0]  operand_a,
  input  wire logic [7:0]  operand_b,
  input  wire logic        irq_request,
  input  wire logic        irq_high,
  input  wire logic [2:0]  irq_src,
  input  wire logic        sp_wr,
  input  wire logic [7:0]  sp_wdata,
  input  wire logic [7:0]  ram_rdata,
  output logic             op_ready,
  output logic             done,
  output logic [15:0]      pc_out,
  output logic [7:0]       stack_pointer,
  output logic [7:0]       ram_addr,
  output logic [7:0]       ram_wdata,
  output logic             ram_we,
  output logic             ram_re,
  output logic             carry_out,
  output logic             carry_we,
  output logic             bit_clear,
  output logic [7:0]       bit_addr,
  output logic [7:0]       dest_data,
  output logic             dest_we,
  output logic             irq_ack,
  output logic [1:0]       in_service
);
  bcsc_state_t state, next_state;
  bcsc_op_t    op_q, next_op;
  logic [15:0] ret_q, next_ret, target_q, next_target, len, seq, rel_target, vec;
  logic        take_q, next_take, accept, irq_ok, irq_take;
  logic        next_done, next_ram_we, next_ram_re, next_carry_out, next_carry_we;
  logic        next_bit_clear, next_dest_we, next_irq_ack;
  logic [15:0] next_pc_out;
  logic [7:0]  next_sp, next_ram_addr, next_ram_wdata, next_bit_addr, next_dest_data, rel;
  logic [1:0]  next_in_service;
  assign op_ready = (state == ST_IDLE);
  assign accept   = op_ready && op_valid;
  assign irq_ok   = irq_high ? !in_service[1] : (in_service == 2'b00);
  assign irq_take = accept && irq_request && irq_ok;
  assign vec      = IRQ_VEC_BASE + {10'h000, irq_src, 3'b000};
  always_comb begin
    case (op_kind)
      OP_JUMP_BIT_SET, OP_JUMP_BIT_CLEAR, OP_JUMP_BIT_THEN_CLEAR,
      OP_LONG_JUMP, OP_LONG_SUBROUTINE_CALL, OP_COMPARE_JUMP_UNEQUAL: len = LEN_THREE;
      OP_DECREMENT_BRANCH_NONZERO: len = decrement_branch_nonzero_direct ? LEN_THREE : LEN_TWO;
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: len = LEN_ONE;
      default: len = LEN_TWO;
    endcase
  end
  // offset in third byte for three-byte forms
  assign rel = (len == LEN_THREE) ? op_byte3 : op_byte2;
  assign seq = op_pc + len;
  assign rel_target = seq + {{8{rel[7]}}, rel};
  always_comb begin
    next_state      = state;
    next_op         = op_q;
    next_ret        = ret_q;
    next_target     = target_q;
    next_take       = take_q;
    next_sp         = stack_pointer;
    next_pc_out     = pc_out;
    next_ram_addr   = ram_addr;
    next_ram_wdata  = ram_wdata;
    next_carry_out  = carry_out;
    next_bit_addr   = bit_addr;
    next_dest_data  = dest_data;
    next_in_service = in_service;
    {next_done, next_ram_we, next_ram_re, next_carry_we} = 4'h0;
    {next_bit_clear, next_dest_we, next_irq_ack} = 3'h0;
    // software load only between instructions; an accepted op overrides
    if (sp_wr && op_ready) begin
      next_sp = sp_wdata;
    end
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state  = ST_S1;
          next_op     = op_kind;
          next_ret    = seq;
          next_target = rel_target;
          next_take   = 1'b0;
          next_sp     = stack_pointer;
          if (irq_take) begin
            // forced long call, return to skipped op
            next_op      = OP_LONG_SUBROUTINE_CALL;
            next_ret     = op_pc;
            next_target  = vec;
            next_irq_ack = 1'b1;
            next_in_service[irq_high] = 1'b1;
          end else begin
            case (op_kind)
              OP_BRANCH_ACCUM_ZERO:    next_take = (accum == 8'h00);
              OP_BRANCH_ACCUM_NONZERO: next_take = (accum != 8'h00);
              OP_BRANCH_ON_CARRY:      next_take = carry_in;
              OP_BRANCH_ON_NO_CARRY:   next_take = !carry_in;
              OP_JUMP_BIT_SET:         next_take = bit_value;
              OP_JUMP_BIT_CLEAR:       next_take = !bit_value;
              OP_JUMP_BIT_THEN_CLEAR: begin
                next_take     = bit_value;
                next_bit_addr = op_byte2;
              end
              OP_SHORT_RELATIVE_JUMP:  next_take = 1'b1;
              OP_LONG_JUMP, OP_LONG_SUBROUTINE_CALL: begin
                next_take   = 1'b1;
                next_target = {op_byte2, op_byte3};
              end
              OP_BLOCK_ABSOLUTE_JUMP, OP_BLOCK_SUBROUTINE_CALL: begin
                next_take   = 1'b1;
                next_target = {seq[15:11], op_page, op_byte2};
              end
              OP_COMPARE_JUMP_UNEQUAL: begin
                next_take      = (operand_a != operand_b);
                next_carry_out = (operand_a < operand_b);
              end
              OP_DECREMENT_BRANCH_NONZERO: begin
                next_dest_data = operand_a - 8'h01;
                next_take      = (next_dest_data != 8'h00);
              end
              default: next_take = 1'b0;
            endcase
          end
          case (next_op)
            OP_LONG_SUBROUTINE_CALL, OP_BLOCK_SUBROUTINE_CALL: begin
              next_ram_addr  = stack_pointer + SP_STEP_ONE;
              next_ram_wdata = next_ret[7:0];
              next_ram_we    = 1'b1;
            end
            OP_PUSH: begin
              next_sp        = stack_pointer + SP_STEP_ONE;
              next_ram_addr  = next_sp;
              next_ram_wdata = operand_a;
              next_ram_we    = 1'b1;
            end
            OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT, OP_POP: begin
              next_ram_addr = stack_pointer;
              next_ram_re   = 1'b1;
            end
            default: next_ram_re = 1'b0;
          endcase
        end
      end
      ST_S1: begin
        next_state = ST_IDLE;
        case (op_q)
          OP_LONG_SUBROUTINE_CALL, OP_BLOCK_SUBROUTINE_CALL: begin
            // high byte, sp up by two
            next_ram_addr  = stack_pointer + SP_STEP_TWO;
            next_ram_wdata = ret_q[15:8];
            next_ram_we    = 1'b1;
            next_sp        = stack_pointer + SP_STEP_TWO;
            next_pc_out    = target_q;
            next_done      = 1'b1;
          end
          OP_PUSH: begin
            next_pc_out = ret_q;
            next_done   = 1'b1;
          end
          OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
            next_ram_addr = stack_pointer - SP_STEP_ONE;
            next_ram_re   = 1'b1;
            next_state    = ST_S2;
          end
          OP_POP: next_state = ST_S2;
          default: begin
            // every jump, taken or not, in two cycles
            next_pc_out    = take_q ? target_q : ret_q;
            next_done      = 1'b1;
            // clear only on the taken path
            next_bit_clear = (op_q == OP_JUMP_BIT_THEN_CLEAR) && take_q;
            next_carry_we  = (op_q == OP_COMPARE_JUMP_UNEQUAL);
            next_dest_we   = (op_q == OP_DECREMENT_BRANCH_NONZERO);
          end
        endcase
      end
      ST_S2: begin
        if (op_q == OP_POP) begin
          next_dest_data = ram_rdata;
          next_dest_we   = 1'b1;
          next_sp        = stack_pointer - SP_STEP_ONE;
          next_pc_out    = ret_q;
          next_done      = 1'b1;
          next_state     = ST_IDLE;
        end else begin
          next_target[15:8] = ram_rdata;
          next_state        = ST_S3;
        end
      end
      ST_S3: begin
        // resume at pushed address, sp down two
        next_pc_out = {target_q[15:8], ram_rdata};
        next_sp     = stack_pointer - SP_STEP_TWO;
        next_done   = 1'b1;
        next_state  = ST_IDLE;
        if (op_q == OP_INTERRUPT_EXIT) begin
          if (in_service[1]) begin
            next_in_service[1] = 1'b0;
          end else begin
            next_in_service[0] = 1'b0;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // 8-bit sp spans 256 bytes; natural wrap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      op_q          <= OP_SHORT_RELATIVE_JUMP;
      {ret_q, target_q, pc_out} <= 48'h0000_0000_0000;
      take_q        <= 1'b0;
      stack_pointer <= SP_RESET;
      {ram_addr, ram_wdata, bit_addr, dest_data} <= 32'h0000_0000;
      carry_out     <= 1'b0;
      in_service    <= 2'b00;
      {done, ram_we, ram_re, carry_we, bit_clear, dest_we, irq_ack} <= 7'h00;
    end else begin
      state         <= next_state;
      op_q          <= next_op;
      {ret_q, target_q, pc_out} <= {next_ret, next_target, next_pc_out};
      take_q        <= next_take;
      stack_pointer <= next_sp;
      {ram_addr, ram_wdata} <= {next_ram_addr, next_ram_wdata};
      carry_out     <= next_carry_out;
      {bit_addr, dest_data} <= {next_bit_addr, next_dest_data};
      in_service    <= next_in_service;
      {done, ram_we, ram_re, carry_we} <= {next_done, next_ram_we, next_ram_re, next_carry_we};
      {bit_clear, dest_we, irq_ack} <= {next_bit_clear, next_dest_we, next_irq_ack};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       acc_plain;
  logic [7:0] sp_acc;
  assign acc_plain = accept && !irq_take;
  always_ff @(posedge ref_clk) begin
    if (accept) begin
      sp_acc <= stack_pointer;
    end
  end

  AST_SHORT_TARGET: assert property (
    acc_plain && op_kind == OP_SHORT_RELATIVE_JUMP |-> ##2
      done && pc_out == $past(op_pc, 2) + LEN_TWO
        + {{8{$past(op_byte2[7], 2)}}, $past(op_byte2, 2)})
    else $error("short jump target wrong");
  AST_CALL_SP: assert property (
    acc_plain && op_kind == OP_BLOCK_SUBROUTINE_CALL |-> ##1 ram_we
      && ram_addr == sp_acc + 8'h01 ##1 done && stack_pointer == sp_acc + 8'h02)
    else $error("call stack update wrong");
  AST_EXIT_SP: assert property (
    acc_plain && op_kind == OP_SUBROUTINE_EXIT |-> ##1 !done [*3] ##1
      done && stack_pointer == sp_acc - 8'h02)
    else $error("exit timing or sp wrong");
  AST_PUSH_ADDR: assert property (
    acc_plain && op_kind == OP_PUSH |=> ram_we && ram_addr == $past(stack_pointer) + 8'h01)
    else $error("push address wrong");
  AST_POP_SP: assert property (
    acc_plain && op_kind == OP_POP |-> ##3 dest_we && stack_pointer == sp_acc - 8'h01)
    else $error("pop sp wrong");
  AST_IRQ_VEC: assert property (
    irq_take && irq_src == 3'h0 |-> ##2 done && pc_out == 16'h0003)
    else $error("vector address wrong");
  AST_IRQ_REFUSE: assert property (
    in_service[1] |=> !irq_ack)
    else $error("nested interrupt accepted");
  AST_CMP_CARRY: assert property (
    acc_plain && op_kind == OP_COMPARE_JUMP_UNEQUAL |-> ##2
      carry_we && carry_out == ($past(operand_a, 2) < $past(operand_b, 2)))
    else $error("compare carry wrong");
  AST_DECREMENT_BRANCH_NONZERO_TWO: assert property (
    acc_plain && op_kind == OP_DECREMENT_BRANCH_NONZERO |-> ##2 done && dest_we && op_ready)
    else $error("decrement not two cycles");
  AST_JBC_CLEAR: assert property (
    acc_plain && op_kind == OP_JUMP_BIT_THEN_CLEAR |-> ##2 bit_clear == $past(bit_value, 2))
    else $error("bit clear mismatch");

  COV_CALL: cover property (acc_plain && op_kind == OP_LONG_SUBROUTINE_CALL ##2 done);
  COV_IRQ: cover property (irq_ack ##1 done);
  COV_INTERRUPT_EXIT: cover property (acc_plain && op_kind == OP_INTERRUPT_EXIT ##4 done);
  COV_JBC: cover property (bit_clear);
endmodule
`default_nettype wire

/* bcsc_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcsc_ram_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] ram_addr,
  input  wire logic [7:0] ram_wdata,
  input  wire logic       ram_we,
  input  wire logic       ram_re,
  output var  logic [7:0] ram_rdata
);
  logic [7:0] mem [256];
  initial ram_rdata = 8'h00;
  always @(posedge ref_clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    // stale data flips so a late sample shows up
    if (ram_re) begin
      ram_rdata <= mem[ram_addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule
`default_nettype wire

/* branch_call_stack_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module branch_call_stack_control_tb_top;
  import bcsc_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, decrement_branch_nonzero_direct = 1'b0;
  logic        carry_in = 1'b0, bit_value = 1'b0, irq_request = 1'b0, irq_high = 1'b0;
  logic        sp_wr = 1'b0;
  bcsc_op_t    op_kind = OP_PUSH;
  logic [15:0] op_pc = 16'h0000;
  logic [7:0]  op_byte2 = 8'h00, op_byte3 = 8'h00, accum = 8'h00, operand_a = 8'h00;
  logic [7:0]  operand_b = 8'h00, sp_wdata = 8'h00;
  logic [2:0]  op_page = 3'h0, irq_src = 3'h0;
  logic [7:0]  ram_rdata, stack_pointer, ram_addr, ram_wdata, bit_addr, dest_data;
  logic [15:0] pc_out;
  logic        op_ready, done, ram_we, ram_re, carry_out, carry_we, bit_clear, dest_we, irq_ack;
  logic [1:0]  in_service;
  int          n_mismatch = 0, num_checks = 0, n_ack = 0, lat = 0;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (irq_ack === 1'b1) n_ack++;

  bcsc_core i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_kind(op_kind),
    .op_pc(op_pc), .op_byte2(op_byte2), .op_byte3(op_byte3), .op_page(op_page),
    .decrement_branch_nonzero_direct(decrement_branch_nonzero_direct), .accum(accum), .carry_in(carry_in), .bit_value(bit_value),
    .operand_a(operand_a), .operand_b(operand_b), .irq_request(irq_request),
    .irq_high(irq_high), .irq_src(irq_src), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
    .ram_rdata(ram_rdata), .op_ready(op_ready), .done(done), .pc_out(pc_out),
    .stack_pointer(stack_pointer), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .carry_out(carry_out), .carry_we(carry_we),
    .bit_clear(bit_clear), .bit_addr(bit_addr), .dest_data(dest_data), .dest_we(dest_we),
    .irq_ack(irq_ack), .in_service(in_service));
  bcsc_ram_model i_ram (.ref_clk(ref_clk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one instruction; returns at the negedge where done is seen
  task automatic do_op(input bcsc_op_t k, input logic [15:0] pc,
                       input logic [7:0] b2, b3, a, b, input logic d);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_pc <= pc;
    op_byte2 <= b2;
    op_byte3 <= b3;
    op_page <= b3[2:0];
    accum <= a;
    operand_a <= a;
    operand_b <= b;
    carry_in <= b[0];
    bit_value <= b[0];
    decrement_branch_nonzero_direct <= d;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge ref_clk);
      lat++;
    end while (done !== 1'b1 && lat < 12);
    if (lat >= 12) chk(16'hDEAD, 16'h0000);
  endtask

  task automatic t_cond();
    logic t;
    for (int i = 0; i < 8; i++) begin
      t = i[0] ^ i[1];
      do_op(bcsc_op_t'(i / 2), 16'h1000, 8'h80, 8'h00, i[0] ? 8'h00 : 8'h5A,
            {7'h00, i[0]}, 1'b0);
      chk(pc_out, t ? 16'h0F82 : 16'h1002);
    end
  endtask

  task automatic t_bit();
    logic t;
    for (int i = 0; i < 6; i++) begin
      t = (i / 2 == 1) ? !i[0] : i[0];
      do_op(bcsc_op_t'(4 + i / 2), 16'h2000, 8'h2C, 8'h7F, 8'h00, {7'h00, i[0]}, 1'b0);
      chk(pc_out, t ? 16'h2082 : 16'h2003);
      chk({15'h0, bit_clear}, {15'h0, t && (i / 2 == 2)});
      if (t && i / 2 == 2) chk({8'h00, bit_addr}, 16'h002C);
    end
  endtask

  task automatic t_call();
    do_op(OP_LONG_SUBROUTINE_CALL, 16'h1234, 8'h56, 8'h78, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h5678);
    // high return byte lands in ram one edge after done
    @(negedge ref_clk);
    chk({i_ram.mem[8'h09], i_ram.mem[8'h08]}, 16'h1237);
    do_op(OP_BLOCK_SUBROUTINE_CALL, 16'h27FE, 8'h9A, 8'h05, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h2D9A);
    @(negedge ref_clk);
    chk({i_ram.mem[8'h0B], i_ram.mem[8'h0A]}, 16'h2800);
    chk({8'h00, stack_pointer}, 16'h000B);
    do_op(OP_SUBROUTINE_EXIT, 16'h2D9A, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h2800);
    do_op(OP_SUBROUTINE_EXIT, 16'h5678, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h1237);
    chk({8'h00, stack_pointer}, 16'h0007);
    do_op(OP_LONG_JUMP, 16'h1234, 8'hAB, 8'hCD, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'hABCD);
    do_op(OP_BLOCK_ABSOLUTE_JUMP, 16'h27FE, 8'h9A, 8'h05, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h2D9A);
    chk({8'h00, stack_pointer}, 16'h0007);
  endtask

  // service code keeps its own registers, so only vectoring, refusal, nesting and the return path are exercised
  task automatic t_irq();
    @(posedge ref_clk);
    irq_request <= 1'b1;
    do_op(OP_SHORT_RELATIVE_JUMP, 16'h0400, 8'h10, 8'h10, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h0003);
    @(negedge ref_clk);
    chk({i_ram.mem[8'h09], i_ram.mem[8'h08]}, 16'h0400);
    chk(16'(n_ack), 16'h0001);
    do_op(OP_SHORT_RELATIVE_JUMP, 16'h0500, 8'h10, 8'h10, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h0512);
    chk(16'(n_ack), 16'h0001);
    @(posedge ref_clk);
    irq_high <= 1'b1;
    irq_src <= 3'h1;
    do_op(OP_SHORT_RELATIVE_JUMP, 16'h0600, 8'h10, 8'h10, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h000B);
    chk({14'h0, in_service}, 16'h0003);
    @(posedge ref_clk);
    irq_request <= 1'b0;
    do_op(OP_INTERRUPT_EXIT, 16'h000B, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h0600);
    chk({14'h0, in_service}, 16'h0001);
    do_op(OP_INTERRUPT_EXIT, 16'h0003, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    chk(pc_out, 16'h0400);
    chk({6'h0, in_service, stack_pointer}, 16'h0007);
  endtask

  task automatic t_cmp();
    logic [7:0] a [3] = '{8'h10, 8'h20, 8'h33};
    logic [7:0] b [3] = '{8'h20, 8'h10, 8'h33};
    for (int i = 0; i < 3; i++) begin
      do_op(OP_COMPARE_JUMP_UNEQUAL, 16'h3000, 8'h05, 8'h05, a[i], b[i], 1'b0);
      chk(pc_out, (a[i] != b[i]) ? 16'h3008 : 16'h3003);
      chk({14'h0, carry_we, carry_out}, {14'h0, 1'b1, a[i] < b[i]});
      chk({15'h0, dest_we}, 16'h0000);
    end
  endtask

  task automatic t_decrement_branch_nonzero();
    do_op(OP_DECREMENT_BRANCH_NONZERO, 16'h4000, 8'h05, 8'h05, 8'h01, 8'h00, 1'b0);
    chk(pc_out, 16'h4002);
    chk({7'h0, dest_we, dest_data}, 16'h0100);
    do_op(OP_DECREMENT_BRANCH_NONZERO, 16'h4000, 8'h05, 8'h05, 8'h00, 8'h00, 1'b1);
    chk(pc_out, 16'h4008);
    chk({6'h0, carry_we, dest_we, dest_data}, 16'h01FF);
    // two machine cycles from take to done
    chk(16'(lat), 16'h0002);
  endtask

  task automatic t_stack();
    @(posedge ref_clk);
    sp_wr <= 1'b1;
    sp_wdata <= 8'hFF;
    @(posedge ref_clk);
    sp_wr <= 1'b0;
    do_op(OP_PUSH, 16'h5000, 8'h40, 8'h00, 8'h5A, 8'h00, 1'b0);
    chk({8'h00, stack_pointer}, 16'h0000);
    chk({8'h00, i_ram.mem[8'h00]}, 16'h005A);
    do_op(OP_POP, 16'h5002, 8'h40, 8'h00, 8'h00, 8'h00, 1'b0);
    chk({7'h0, dest_we, dest_data}, 16'h015A);
    chk({8'h00, stack_pointer}, 16'h00FF);
    chk(pc_out, 16'h5004);
  endtask

  initial begin
    #40000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({5'h0, op_ready, in_service, stack_pointer}, 16'h0407);
    chk(pc_out, 16'h0000);
    t_cond();
    t_bit();
    t_call();
    t_irq();
    t_cmp();
    t_decrement_branch_nonzero();
    t_stack();
    stop_test();
  end
endmodule
`default_nettype wire
